// ---- logic/mts_arbiter_timer.v ----
// Overview of operation
// - 8-bit read/write slice timer register at offset 70h, reset value 00h.
// - one initiator may run back-to-back transactions for a bounded time before rearbitration.
// - bits 7:3 give the guaranteed slice in PCI clocks for the current owner.
// - after the slice expires, grant another initiator as soon as one requests.
// - a register value of zero disables the time slice mechanism.
// - slice length is in steps of 8 clocks; value with low bits zero is clocks.
`timescale 1ns/10ps
`include "mts_regs.vh"
module mts_arbiter_timer #(
    parameter NUM_INIT = 5,
    parameter IDX_W = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [NUM_INIT-1:0] pci_req_n,
    output reg [NUM_INIT-1:0] pci_gnt_n
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// full-width reset value so the stored field can be cut from it with a part-select
localparam [7:0] SLICE_RESET_VAL = `MTS_SLICE_RESET;

// only the low 256 bytes are decoded; anything above reads zero and ignores writes
function addr_in_page;
    input [31:0] addr;
    begin
        addr_in_page = (addr[31:8] == 24'h000000);
    end
endfunction

function [NUM_INIT-1:0] idx_onehot;
    input [IDX_W-1:0] idx;
    integer k;
    begin
        idx_onehot = {NUM_INIT{1'b0}};
        for (k = 0; k < NUM_INIT; k = k + 1) begin
            if (idx == k[IDX_W-1:0]) begin
                idx_onehot[k] = 1'b1;
            end
        end
    end
endfunction

// round robin pick starting one past the current owner; msb flags a hit
function [IDX_W:0] rr_pick;
    input [NUM_INIT-1:0] reqs;
    input [IDX_W-1:0] last;
    integer i;
    integer j;
    reg found;
    begin
        found = 1'b0;
        rr_pick = {(IDX_W+1){1'b0}};
        for (i = 1; i <= NUM_INIT; i = i + 1) begin
            j = (last + i) % NUM_INIT;
            if (!found && reqs[j]) begin
                found = 1'b1;
                rr_pick = {1'b1, j[IDX_W-1:0]};
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// request pins come from other agents: two flops before any use

reg [NUM_INIT-1:0] req_meta_reg;
reg [NUM_INIT-1:0] req_sync_reg;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        req_meta_reg <= {NUM_INIT{1'b0}};
        req_sync_reg <= {NUM_INIT{1'b0}};
    end else begin
        req_meta_reg <= ~pci_req_n;
        req_sync_reg <= req_meta_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// ahb-lite register slave, zero wait states

reg [4:0] slice_field_reg;
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
wire addr_phase;
wire [7:0] slice_value;
wire [7:0] slice_count;
wire slice_expired;
reg [IDX_W-1:0] owner_reg;
reg owned_reg;
reg [31:0] rd_next;
wire slice_wr;

assign addr_phase = hsel && hready && htrans[`MTS_HTRANS_NONSEQ_BIT];
// low three bits are reserved and always zero, giving 8 clock granularity
assign slice_value = {slice_field_reg, {`MTS_SLICE_STEP_BITS{1'b0}}};
// the write lands in the data phase, when hwdata stands
assign slice_wr = wr_pend_reg && (wr_addr_reg == `MTS_SLICE_TIMER_ADDR);

always @* begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
        `MTS_SLICE_TIMER_ADDR: begin
            rd_next[7:0] = slice_value;
        end
        `MTS_SLICE_STATUS_ADDR: begin
            rd_next[`MTS_STAT_COUNT_HI:`MTS_STAT_COUNT_LO] = slice_count;
            rd_next[`MTS_STAT_EXPIRED_BIT] = slice_expired;
            rd_next[`MTS_STAT_OWNED_BIT] = owned_reg;
            rd_next[`MTS_STAT_OWNER_HI:`MTS_STAT_OWNER_LO] = owner_reg;
        end
        default: begin
            rd_next = 32'h0000_0000;
        end
    endcase
    if (!addr_in_page(haddr)) begin
        rd_next = 32'h0000_0000;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b0;
        hresp <= `MTS_HRESP_OKAY;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        slice_field_reg <= SLICE_RESET_VAL[`MTS_SLICE_FIELD_HI:`MTS_SLICE_FIELD_LO];
    end else begin
        hreadyout <= 1'b1;
        hresp <= `MTS_HRESP_OKAY;
        // read data is fetched in the address phase so it stands in the data phase
        if (addr_phase && !hwrite) begin
            hrdata <= rd_next;
        end
        wr_pend_reg <= addr_phase && hwrite && addr_in_page(haddr);
        if (addr_phase) begin
            wr_addr_reg <= haddr[7:0];
        end
        if (slice_wr) begin
            slice_field_reg <= hwdata[`MTS_SLICE_FIELD_HI:`MTS_SLICE_FIELD_LO];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// arbiter with slice timer

wire [NUM_INIT-1:0] others_req;
wire slice_enabled;
wire owner_req;
wire [IDX_W:0] pick;
reg hand_over;
reg load_slice;
wire [NUM_INIT-1:0] owner_mask;

assign slice_enabled = (slice_field_reg != 5'h00);
assign owner_mask = owned_reg ? idx_onehot(owner_reg) : {NUM_INIT{1'b0}};
assign owner_req = |(req_sync_reg & owner_mask);
assign others_req = req_sync_reg & ~owner_mask;
assign pick = rr_pick(others_req, owner_reg);

always @* begin
    hand_over = 1'b0;
    if (!owner_req) begin
        // owner dropped its request: anyone else may take the bus
        hand_over = pick[IDX_W];
    end else if (!slice_enabled) begin
        // mechanism off: no guaranteed slice, yield whenever another asks
        hand_over = pick[IDX_W];
    end else if (slice_expired) begin
        hand_over = pick[IDX_W];
    end
    // while the slice runs the owner keeps the bus for back-to-back cycles
    load_slice = hand_over;
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        owner_reg <= {IDX_W{1'b0}};
        owned_reg <= 1'b0;
        pci_gnt_n <= {NUM_INIT{1'b1}};
    end else begin
        if (hand_over) begin
            owner_reg <= pick[IDX_W-1:0];
            owned_reg <= 1'b1;
            pci_gnt_n <= ~idx_onehot(pick[IDX_W-1:0]);
        end else if (!owner_req) begin
            // nobody requests; park with no grant
            owned_reg <= 1'b0;
            pci_gnt_n <= {NUM_INIT{1'b1}};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// slice counter

// a nonzero write in mid-slice takes effect at the next grant, a write of zero at once; the running slice is not reloaded
mts_slice_counter #(
    .WIDTH(8)
) u_slice_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(load_slice),
    .load_value(slice_value),
    .run(owner_req && !hand_over),
    .count(slice_count),
    .expired(slice_expired)
);

endmodule // mts_arbiter_timer

// ---- logic/mts_regs.vh ----
`ifndef MTS_REGS_VH
`define MTS_REGS_VH

// register byte addresses
`define MTS_SLICE_TIMER_ADDR 8'h70
`define MTS_SLICE_STATUS_ADDR 8'h74

// slice timer register layout
`define MTS_SLICE_RESET 8'h00
`define MTS_SLICE_FIELD_HI 7
`define MTS_SLICE_FIELD_LO 3
`define MTS_SLICE_STEP_BITS 3

// slice status register layout
`define MTS_STAT_COUNT_HI 7
`define MTS_STAT_COUNT_LO 0
`define MTS_STAT_EXPIRED_BIT 8
`define MTS_STAT_OWNED_BIT 9
`define MTS_STAT_OWNER_LO 10
`define MTS_STAT_OWNER_HI 12

// ahb encodings
`define MTS_HTRANS_NONSEQ_BIT 1
`define MTS_HRESP_OKAY 1'b0

`endif

// ---- logic/mts_slice_counter.v ----
`timescale 1ns/10ps
module mts_slice_counter #(
    parameter WIDTH = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    input wire run,
    output wire [WIDTH-1:0] count,
    output wire expired
);

reg [WIDTH-1:0] count_reg;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        count_reg <= {WIDTH{1'b0}};
    end else if (load) begin
        count_reg <= load_value;
    end else if (run && count_reg != {WIDTH{1'b0}}) begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

assign count = count_reg;
// a slice of zero clocks is already used up
assign expired = (count_reg == {WIDTH{1'b0}});

endmodule // mts_slice_counter

// ---- test/mts_chk_asserts.sv ----
`timescale 1ns/10ps
module mts_chk #(
    parameter NUM_INIT = 5
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [NUM_INIT-1:0] pci_req_n,
    input wire [NUM_INIT-1:0] pci_gnt_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow of the slice register; hold_reg counts cycles a waiting requester is kept out
    logic wp_reg;
    logic [7:0] mir_reg;
    logic [8:0] hold_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_reg <= 1'h0;
            mir_reg <= 8'h00;
            hold_reg <= 9'h000;
        end else begin
            wp_reg <= hsel && hready && htrans[1] && hwrite && haddr == 32'h70;
            if (wp_reg) mir_reg <= hwdata[7:0] & 8'hf8;
            hold_reg <= ($stable(pci_gnt_n) && !(&pci_gnt_n) && |(~pci_req_n & pci_gnt_n)) ? hold_reg + 9'h1 : 9'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_rd(a);
        hsel && hready && htrans[1] && !hwrite && haddr == a;
    endsequence
    sequence s_owned;
        !(&pci_gnt_n) ##1 $stable(pci_gnt_n);
    endsequence
    property p_okay; hresp == 1'h0; endproperty
    property p_ready; $past(hresetn) |-> hreadyout; endproperty
    property p_onehot; $onehot0(~pci_gnt_n); endproperty
    property p_req; (~pci_gnt_n & $past(pci_req_n, 3)) == '0; endproperty
    property p_rdcfg; s_rd(32'h70) ##0 !wp_reg |=> hrdata == {24'h0, mir_reg}; endproperty
    property p_rdnone; s_rd(32'h40) |=> hrdata == 32'h0; endproperty
    property p_hold; hold_reg <= {1'h0, mir_reg} + 9'h6; endproperty
    property p_stat; s_rd(32'h74) ##0 s_owned |-> !pci_gnt_n[hrdata[12:10]] && hrdata[9]; endproperty
    a_okay: assert property (p_okay) else $error("resp");
    a_ready: assert property (p_ready) else $error("ready");
    a_onehot: assert property (p_onehot) else $error("two grants");
    a_req: assert property (p_req) else $error("grant without request");
    a_rdcfg: assert property (p_rdcfg) else $error("slice readback");
    a_rdnone: assert property (p_rdnone) else $error("unmapped read");
    a_hold: assert property (p_hold) else $error("slice overrun");
    a_stat: assert property (p_stat) else $error("owner index");
endmodule // mts_chk
bind mts_arbiter_timer mts_chk #(.NUM_INIT(NUM_INIT)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pci_req_n, .pci_gnt_n);

// ---- test/mts_pci_init.sv ----
`timescale 1ns/10ps
// initiators: each holds its request while it has back-to-back transactions queued
module mts_pci_init #(
    parameter N = 5
) (
    input wire hclk,
    input wire [N-1:0] want,
    output logic [N-1:0] pci_req_n
);
    initial pci_req_n = '1;
    always @(posedge hclk) pci_req_n <= ~want;
endmodule // mts_pci_init

// ---- test/pci_multi_transaction_slice_timer_test.sv ----
`timescale 1ns/10ps
module pci_multi_transaction_slice_timer_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [4:0] want = 0, pci_req_n, pci_gnt_n;
    logic [7:0] vals [4] = '{8'h00, 8'h07, 8'h18, 8'h00};
    int miscompares = 0, total_checks = 0, k;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    mts_arbiter_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .pci_req_n, .pci_gnt_n);
    mts_pci_init #(.N(5)) u_init (.hclk, .want, .pci_req_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input [31:0] s, input [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // readback of the slice register: bits 7:3 kept, reserved bits read zero
    function automatic [31:0] exp_slice(input [31:0] v);
        return v & 32'h0000_00f8;
    endfunction
    task automatic xfer(input logic w, input [31:0] a, input [31:0] d);
        hsel <= 1'h1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        r = hrdata;
    endtask
    // bounded wait; k is the number of edges until the grant shows
    task automatic wt(input int i);
        k = 0;
        while (pci_gnt_n[i] !== 1'h0 && k < 600) begin
            @(posedge hclk);
            k++;
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        miscompares++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'h7a4e1604));
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(0, 32'h70, 0);
        chk(r, 32'h0);
        xfer(0, 32'h40, 0);
        chk(r, 32'h0);
        repeat (6) begin
            k = $urandom;
            xfer(1, 32'h70, k);
            xfer(0, 32'h70, 0);
            chk(r, exp_slice(k));
        end
        // reset in mid-run must bring the slice register back to its reset value
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(0, 32'h70, 0);
        chk(r, 32'h0);
        vals[3] = $urandom;
        // zero, low bits only, 24 clocks, random: second requester waits out the slice
        foreach (vals[j]) begin
            xfer(1, 32'h70, vals[j]);
            want <= 5'h1;
            wt(0);
            // free bus: initiator flop, two sync flops and the grant flop, seen one edge later
            chk(k, 32'h5);
            want <= 5'h3;
            wt(1);
            chk(k >= exp_slice(vals[j]) && k <= exp_slice(vals[j]) + 32'h6, 32'h1);
            want <= 5'h2;
            repeat (6) @(posedge hclk);
            xfer(0, 32'h74, 0);
            chk(r[12:9], 4'h3);
            want <= 5'h0;
            repeat (8) @(posedge hclk);
        end
        end_of_test;
    end
endmodule // pci_multi_transaction_slice_timer_test
